// *** rceq_regs.vh ***
// Function
// - error queue reads return oldest first
// - error indicator lit while queue not empty
// - one beeper pulse per new error
// - full queue: newest entry becomes overflow code
// - after overflow drop errors until a read
// - empty queue read returns zero
// - power-up and clear-status empty the queue
// - reset command leaves queue untouched
// - trigger honoured only in wait-for-trigger
// - arm commands move idle to wait-for-trigger
// - trigger source immediate, bus or external
// - at most one math operation active
// - no math in continuity or diode
// - log -101, -102, -103 syntax faults
// - log -104, -108, -109 parameter faults
// - log -105 for trigger inside string
// - log -112 long header, -113 unknown
// - log -121 bad character in number
// - log -123 exponent above 32000
// - log -124 mantissa above 255 digits
// - log -131 bad suffix, -138 suffix unwanted
// - log -148 keyword where value expected
// - log -211 for unhonoured bus trigger
// - log -213 read query with bus source
// - log -214 arming during measurement
// - log -230 fetch with empty memory
`ifndef RCEQ_REGS_VH
`define RCEQ_REGS_VH

`define RCEQ_DEPTH        5'h14
`define RCEQ_PTR_W        5
`define RCEQ_CODE_W       16

// fault classes presented by the parser
`define RCEQ_F_NONE       5'h00
`define RCEQ_F_INV_CHAR   5'h01
`define RCEQ_F_SYNTAX     5'h02
`define RCEQ_F_SEPARATOR  5'h03
`define RCEQ_F_DATA_TYPE  5'h04
`define RCEQ_F_GET_IN_STR 5'h05
`define RCEQ_F_PARM_EXTRA 5'h06
`define RCEQ_F_PARM_MISS  5'h07
`define RCEQ_F_HDR_LONG   5'h08
`define RCEQ_F_HDR_UNDEF  5'h09
`define RCEQ_F_NUM_CHAR   5'h0A
`define RCEQ_F_SUF_BAD    5'h0B
`define RCEQ_F_SUF_UNWANT 5'h0C
`define RCEQ_F_CHAR_PARM  5'h0D

// signed error codes, two's complement
`define RCEQ_E_NONE       16'h0000
`define RCEQ_E_INV_CHAR   16'hFF9B
`define RCEQ_E_SYNTAX     16'hFF9A
`define RCEQ_E_SEPARATOR  16'hFF99
`define RCEQ_E_DATA_TYPE  16'hFF98
`define RCEQ_E_GET_IN_STR 16'hFF97
`define RCEQ_E_PARM_EXTRA 16'hFF94
`define RCEQ_E_PARM_MISS  16'hFF93
`define RCEQ_E_HDR_LONG   16'hFF90
`define RCEQ_E_HDR_UNDEF  16'hFF8F
`define RCEQ_E_NUM_CHAR   16'hFF87
`define RCEQ_E_NUM_OVF    16'hFF85
`define RCEQ_E_TOO_DIGITS 16'hFF84
`define RCEQ_E_SUF_BAD    16'hFF7D
`define RCEQ_E_SUF_UNWANT 16'hFF76
`define RCEQ_E_CHAR_PARM  16'hFF6C
`define RCEQ_E_TRG_IGN    16'hFF2D
`define RCEQ_E_TRG_DEAD   16'hFF2B
`define RCEQ_E_INIT_IGN   16'hFF2A
`define RCEQ_E_DATA_STALE 16'hFF1A
`define RCEQ_E_TOO_MANY   16'hFEA2

// numeric limits
`define RCEQ_EXP_MAX      16'h7D00
`define RCEQ_DIGITS_MAX   9'h0FF

// trigger sources
`define RCEQ_SRC_IMM      2'h0
`define RCEQ_SRC_BUS      2'h1
`define RCEQ_SRC_EXT      2'h2

// measurement functions needing no math
`define RCEQ_FN_CONT      4'h9
`define RCEQ_FN_DIODE     4'hA

`endif

// *** rceq_mem.v ***
`timescale 1ns/100ps
`include "rceq_regs.vh"
module rceq_mem (
    // clock
    input  wire                    ref_clk_i,
    // write port
    input  wire                    wr_en_i,
    input  wire [`RCEQ_PTR_W-1:0]  wr_addr_i,
    input  wire [`RCEQ_CODE_W-1:0] wr_data_i,
    // read port
    input  wire [`RCEQ_PTR_W-1:0]  rd_addr_i,
    output reg  [`RCEQ_CODE_W-1:0] rd_data_o
);

reg [`RCEQ_CODE_W-1:0] mem_r [0:`RCEQ_DEPTH-1];

always @(posedge ref_clk_i) begin
    if (wr_en_i) begin
        mem_r[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_r[rd_addr_i];
end

endmodule

// *** rceq_trig.v ***
`timescale 1ns/100ps
`include "rceq_regs.vh"
module rceq_trig (
    // clock and reset
    input  wire       ref_clk_i,
    input  wire       rst_b_i,
    // commands
    input  wire       arm_i,
    input  wire       bus_trg_i,
    input  wire       ext_trg_i,
    input  wire [1:0] trg_src_i,
    input  wire       meas_done_i,
    // status
    output reg        wait_trg_o,
    output reg        meas_busy_o,
    output reg        meas_start_o,
    output reg        trg_ignored_o,
    output reg        init_ignored_o
);

localparam ST_IDLE = 2'h0;
localparam ST_WAIT = 2'h1;
localparam ST_MEAS = 2'h2;

reg [1:0] st_r;
reg [1:0] st_nxt;
reg       fire;

always @* begin
    case (trg_src_i)
        `RCEQ_SRC_IMM: fire = 1'b1;
        `RCEQ_SRC_BUS: fire = bus_trg_i;
        `RCEQ_SRC_EXT: fire = ext_trg_i;
        default:       fire = 1'b0;
    endcase
end

always @* begin
    st_nxt = st_r;
    case (st_r)
        ST_IDLE: if (arm_i) st_nxt = ST_WAIT;
        ST_WAIT: if (fire) st_nxt = ST_MEAS;
        ST_MEAS: if (meas_done_i) st_nxt = ST_IDLE;
        default: st_nxt = ST_IDLE;
    endcase
end

always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
        st_r           <= ST_IDLE;
        wait_trg_o     <= 1'b0;
        meas_busy_o    <= 1'b0;
        meas_start_o   <= 1'b0;
        trg_ignored_o  <= 1'b0;
        init_ignored_o <= 1'b0;
    end else begin
        st_r           <= st_nxt;
        wait_trg_o     <= (st_nxt == ST_WAIT);
        meas_busy_o    <= (st_nxt == ST_MEAS);
        meas_start_o   <= (st_r == ST_WAIT) && fire;
        trg_ignored_o  <= bus_trg_i && !((st_r == ST_WAIT)
                          && (trg_src_i == `RCEQ_SRC_BUS));
        init_ignored_o <= arm_i && (st_r == ST_MEAS);
    end
end

endmodule

// *** rceq_top.v ***
`timescale 1ns/100ps
`include "rceq_regs.vh"
module rceq_top (
    // clock and reset
    input  wire                    ref_clk_i,
    input  wire                    rst_b_i,
    // parser fault reports
    input  wire                    fault_vld_i,
    input  wire [4:0]              fault_cls_i,
    input  wire                    num_vld_i,
    input  wire [15:0]             num_exp_i,
    input  wire [8:0]              num_digits_i,
    // common commands
    input  wire                    cls_i,
    input  wire                    rst_cmd_i,
    // error queue read
    input  wire                    err_rd_i,
    output reg                     err_rd_vld_o,
    output reg  [`RCEQ_CODE_W-1:0] err_code_o,
    // indicators
    output reg                     err_lamp_o,
    output reg                     beep_o,
    output reg  [`RCEQ_PTR_W-1:0]  err_count_o,
    // trigger commands
    input  wire                    init_cmd_i,
    input  wire                    read_cmd_i,
    input  wire                    meas_cmd_i,
    input  wire                    bus_trg_i,
    input  wire                    ext_trg_i,
    input  wire [1:0]              trg_src_i,
    input  wire                    meas_done_i,
    input  wire                    fetch_cmd_i,
    input  wire                    mem_empty_i,
    output reg                     wait_trg_o,
    output reg                     meas_start_o,
    // math selection
    input  wire                    math_en_i,
    input  wire [2:0]              math_sel_i,
    input  wire                    math_off_i,
    input  wire [3:0]              meas_fn_i,
    output reg  [7:0]              math_onehot_o
);

////////////////////////////////////////////////////////////////////////
function [`RCEQ_CODE_W-1:0] cls_code;
    input [4:0] cls;
    begin
        case (cls)
            `RCEQ_F_INV_CHAR:   cls_code = `RCEQ_E_INV_CHAR;
            `RCEQ_F_SYNTAX:     cls_code = `RCEQ_E_SYNTAX;
            `RCEQ_F_SEPARATOR:  cls_code = `RCEQ_E_SEPARATOR;
            `RCEQ_F_DATA_TYPE:  cls_code = `RCEQ_E_DATA_TYPE;
            `RCEQ_F_PARM_EXTRA: cls_code = `RCEQ_E_PARM_EXTRA;
            `RCEQ_F_PARM_MISS:  cls_code = `RCEQ_E_PARM_MISS;
            `RCEQ_F_GET_IN_STR: cls_code = `RCEQ_E_GET_IN_STR;
            `RCEQ_F_HDR_LONG:   cls_code = `RCEQ_E_HDR_LONG;
            `RCEQ_F_HDR_UNDEF:  cls_code = `RCEQ_E_HDR_UNDEF;
            `RCEQ_F_NUM_CHAR:   cls_code = `RCEQ_E_NUM_CHAR;
            `RCEQ_F_SUF_BAD:    cls_code = `RCEQ_E_SUF_BAD;
            `RCEQ_F_SUF_UNWANT: cls_code = `RCEQ_E_SUF_UNWANT;
            `RCEQ_F_CHAR_PARM:  cls_code = `RCEQ_E_CHAR_PARM;
            default:            cls_code = `RCEQ_E_NONE;
        endcase
    end
endfunction

function [`RCEQ_PTR_W-1:0] ptr_inc;
    input [`RCEQ_PTR_W-1:0] p;
    begin
        if (p == `RCEQ_DEPTH - 5'h01) begin
            ptr_inc = 5'h00;
        end else begin
            ptr_inc = p + 5'h01;
        end
    end
endfunction

function [`RCEQ_PTR_W-1:0] ptr_dec;
    input [`RCEQ_PTR_W-1:0] p;
    begin
        if (p == 5'h00) begin
            ptr_dec = `RCEQ_DEPTH - 5'h01;
        end else begin
            ptr_dec = p - 5'h01;
        end
    end
endfunction

function [`RCEQ_CODE_W-1:0] num_code;
    input [15:0] exp_v;
    input [8:0]  digits;
    begin
        if (exp_v > `RCEQ_EXP_MAX) begin
            num_code = `RCEQ_E_NUM_OVF;
        end else if (digits > `RCEQ_DIGITS_MAX) begin
            num_code = `RCEQ_E_TOO_DIGITS;
        end else begin
            num_code = `RCEQ_E_NONE;
        end
    end
endfunction

// trigger-side errors, all below the parser
function [`RCEQ_CODE_W-1:0] trg_code;
    input ign;
    input dead;
    input init_ign;
    input stale;
    begin
        if (ign) begin
            trg_code = `RCEQ_E_TRG_IGN;
        end else if (dead) begin
            trg_code = `RCEQ_E_TRG_DEAD;
        end else if (init_ign) begin
            trg_code = `RCEQ_E_INIT_IGN;
        end else if (stale) begin
            trg_code = `RCEQ_E_DATA_STALE;
        end else begin
            trg_code = `RCEQ_E_NONE;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////
// trigger system
wire arm;
wire wait_trg;
wire meas_start;
wire trg_ignored;
wire init_ignored;

assign arm = init_cmd_i || read_cmd_i || meas_cmd_i;

rceq_trig u_trig (
    .ref_clk_i      (ref_clk_i),
    .rst_b_i        (rst_b_i),
    .arm_i          (arm),
    .bus_trg_i      (bus_trg_i),
    .ext_trg_i      (ext_trg_i),
    .trg_src_i      (trg_src_i),
    .meas_done_i    (meas_done_i),
    .wait_trg_o     (wait_trg),
    .meas_busy_o    (),
    .meas_start_o   (meas_start),
    .trg_ignored_o  (trg_ignored),
    .init_ignored_o (init_ignored)
);

////////////////////////////////////////////////////////////////////////
// error sources, one cycle late for the trigger ones
reg        deadlock_r;
reg        stale_r;
reg [15:0] parse_code;
reg [15:0] new_code;
reg        new_err;

always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
        deadlock_r <= 1'b0;
    end else begin
        deadlock_r <= read_cmd_i && (trg_src_i == `RCEQ_SRC_BUS);
    end
end

always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
        stale_r <= 1'b0;
    end else begin
        stale_r <= fetch_cmd_i && mem_empty_i;
    end
end

always @* begin
    parse_code = `RCEQ_E_NONE;
    if (fault_vld_i) begin
        parse_code = cls_code(fault_cls_i);
    end else if (num_vld_i) begin
        parse_code = num_code(num_exp_i, num_digits_i);
    end
end

// one error per cycle, parser first
always @* begin
    new_code = parse_code;
    if (parse_code == `RCEQ_E_NONE) begin
        new_code = trg_code(trg_ignored, deadlock_r, init_ignored, stale_r);
    end
    new_err = (new_code != `RCEQ_E_NONE);
end

////////////////////////////////////////////////////////////////////////
// error queue
reg  [`RCEQ_PTR_W-1:0] wr_ptr_r;
reg  [`RCEQ_PTR_W-1:0] rd_ptr_r;
reg  [`RCEQ_PTR_W-1:0] cnt_r;
reg                    ovf_r;
reg                    rd_pend_r;
reg                    rd_empty_r;
reg                    mem_we;
reg  [`RCEQ_PTR_W-1:0] mem_wa;
reg  [15:0]            mem_wd;
wire [15:0]            mem_rd;
wire                   do_rd;
wire                   full;

assign do_rd = err_rd_i && (cnt_r != 5'h00) && !cls_i;
assign full  = (cnt_r == `RCEQ_DEPTH);

always @* begin
    mem_we = 1'b0;
    mem_wa = wr_ptr_r;
    mem_wd = new_code;
    if (new_err && !cls_i) begin
        if (full && !do_rd) begin
            if (!ovf_r) begin
                mem_we = 1'b1;
                mem_wa = ptr_dec(wr_ptr_r);
                mem_wd = `RCEQ_E_TOO_MANY;
            end
        end else if (!ovf_r || do_rd) begin
            mem_we = 1'b1;
        end
    end
end

rceq_mem u_mem (
    .ref_clk_i (ref_clk_i),
    .wr_en_i   (mem_we),
    .wr_addr_i (mem_wa),
    .wr_data_i (mem_wd),
    .rd_addr_i (rd_ptr_r),
    .rd_data_o (mem_rd)
);

// rst_cmd_i deliberately does not touch queue state
wire wr_adv;

// an append moves wr_ptr_r; the overflow overwrite does not
assign wr_adv = mem_we && (mem_wa == wr_ptr_r);

always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
        wr_ptr_r <= 5'h00;
        rd_ptr_r <= 5'h00;
    end else if (cls_i) begin
        wr_ptr_r <= 5'h00;
        rd_ptr_r <= 5'h00;
    end else begin
        if (do_rd) begin
            rd_ptr_r <= ptr_inc(rd_ptr_r);
        end
        if (wr_adv) begin
            wr_ptr_r <= ptr_inc(wr_ptr_r);
        end
    end
end

always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
        cnt_r <= 5'h00;
    end else if (cls_i) begin
        cnt_r <= 5'h00;
    end else begin
        case ({wr_adv, do_rd})
            2'b10:   cnt_r <= cnt_r + 5'h01;
            2'b01:   cnt_r <= cnt_r - 5'h01;
            default: cnt_r <= cnt_r;
        endcase
    end
end

// a read frees a slot, so it also reopens the queue
always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
        ovf_r <= 1'b0;
    end else if (cls_i || do_rd) begin
        ovf_r <= 1'b0;
    end else if (mem_we && !wr_adv) begin
        ovf_r <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////
// indicators
always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
        beep_o      <= 1'b0;
        err_lamp_o  <= 1'b0;
        err_count_o <= 5'h00;
    end else begin
        beep_o      <= new_err;
        err_lamp_o  <= (cnt_r != 5'h00);
        err_count_o <= cnt_r;
    end
end

////////////////////////////////////////////////////////////////////////
// read answer, two edges late as the memory read is registered
always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
        rd_pend_r    <= 1'b0;
        rd_empty_r   <= 1'b0;
        err_rd_vld_o <= 1'b0;
        err_code_o   <= `RCEQ_E_NONE;
    end else begin
        rd_pend_r    <= err_rd_i;
        rd_empty_r   <= !do_rd;
        err_rd_vld_o <= rd_pend_r;
        if (rd_pend_r) begin
            err_code_o <= rd_empty_r ? `RCEQ_E_NONE : mem_rd;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// math selection
wire math_blocked;

assign math_blocked = (meas_fn_i == `RCEQ_FN_CONT) ||
                      (meas_fn_i == `RCEQ_FN_DIODE);

// trigger status, one stage behind the state machine
always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
        wait_trg_o   <= 1'b0;
        meas_start_o <= 1'b0;
    end else begin
        wait_trg_o   <= wait_trg;
        meas_start_o <= meas_start;
    end
end

always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
        math_onehot_o <= 8'h00;
    end else if (math_blocked || math_off_i) begin
        math_onehot_o <= 8'h00;
    end else if (math_en_i) begin
        math_onehot_o <= 8'h01 << math_sel_i;
    end
end

endmodule

// *** rceq_asserts.sv ***
`timescale 1ns/100ps
module rceq_asserts (
    // clock and reset
    input wire        ref_clk_i,
    input wire        rst_b_i,
    // watched inputs
    input wire        fault_vld_i,
    input wire [4:0]  fault_cls_i,
    input wire        cls_i,
    input wire        err_rd_i,
    input wire [3:0]  meas_fn_i,
    // watched outputs
    input wire        err_rd_vld_o,
    input wire [15:0] err_code_o,
    input wire        err_lamp_o,
    input wire        beep_o,
    input wire [4:0]  err_count_o,
    input wire        wait_trg_o,
    input wire        meas_start_o,
    input wire [7:0]  math_onehot_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////////////
    // room left for one write still in flight
    a_beep_per_fault: assert property (
        fault_vld_i && fault_cls_i != 5'h00 && fault_cls_i < 5'h0E
        && err_count_o < 5'h12 && !cls_i |=> beep_o)
        else $error("beep missing after fault");
    a_lamp_count: assert property (
        err_lamp_o == (err_count_o != 5'h00))
        else $error("lamp disagrees with count");
    a_count_limit: assert property (
        err_count_o <= 5'h14)
        else $error("queue count above depth");
    a_clear_empties: assert property (
        cls_i |-> ##2 err_count_o == 5'h00)
        else $error("clear did not empty queue");
    a_read_answer: assert property (
        err_rd_i && !cls_i |-> ##2 err_rd_vld_o)
        else $error("read not answered");
    a_valid_cause: assert property (
        err_rd_vld_o |-> $past(err_rd_i, 2))
        else $error("read valid without read");
    a_code_sign: assert property (
        err_rd_vld_o |-> err_code_o[15] || err_code_o == 16'h0000)
        else $error("read code neither negative nor zero");
    a_start_waits: assert property (
        meas_start_o |-> $past(wait_trg_o, 1))
        else $error("measurement started outside wait");
    a_math_single: assert property (
        $onehot0(math_onehot_o))
        else $error("several math operations active");
    a_math_blocked: assert property (
        (meas_fn_i == 4'h9 || meas_fn_i == 4'hA) [*3]
        |-> math_onehot_o == 8'h00)
        else $error("math active in continuity or diode");
endmodule

// *** rceq_host.sv ***
`timescale 1ns/100ps
module rceq_host (
    // clock
    input  wire  ref_clk_i,
    // host requests
    output logic err_rd_o,
    output logic init_o,
    output logic read_o,
    output logic meas_o,
    output logic bus_trg_o
);
    initial begin
        {err_rd_o, init_o, read_o, meas_o, bus_trg_o} = 5'h00;
    end
    ////////////////////////////////////////////////////////////////////////////
    task rd();
        @(negedge ref_clk_i) err_rd_o = 1'b1;
        @(negedge ref_clk_i) err_rd_o = 1'b0;
    endtask
    // k: 0 initiate, 1 read query, 2 measure query
    task arm(input int k);
        @(negedge ref_clk_i) {init_o, read_o, meas_o} = 3'h4 >> k;
        @(negedge ref_clk_i) {init_o, read_o, meas_o} = 3'h0;
    endtask
    task fire();
        @(negedge ref_clk_i) bus_trg_o = 1'b1;
        @(negedge ref_clk_i) bus_trg_o = 1'b0;
    endtask
endmodule

// *** test_remote_command_error_queue.sv ***
`timescale 1ns/100ps
`include "rceq_regs.vh"
module test_remote_command_error_queue;
    logic        ref_clk_i, rst_b_i, fault_vld_i, mem_empty_i, ovf;
    logic        err_rd_i, init_cmd_i, read_cmd_i, meas_cmd_i, bus_trg_i;
    logic        err_rd_vld_o, err_lamp_o, beep_o, wait_trg_o, meas_start_o;
    logic [4:0]  fault_cls_i, err_count_o;
    logic [15:0] num_exp_i, err_code_o, mq[$], exp_q[$];
    logic [8:0]  num_digits_i;
    logic [1:0]  trg_src_i;
    logic [2:0]  math_sel_i;
    logic [3:0]  meas_fn_i;
    logic [7:0]  math_onehot_o, cmd;
    int          bad_count, tests_run, seed, i;
    logic [15:0] ecode [0:13] = '{`RCEQ_E_NONE, `RCEQ_E_INV_CHAR,
        `RCEQ_E_SYNTAX, `RCEQ_E_SEPARATOR, `RCEQ_E_DATA_TYPE,
        `RCEQ_E_GET_IN_STR, `RCEQ_E_PARM_EXTRA, `RCEQ_E_PARM_MISS,
        `RCEQ_E_HDR_LONG, `RCEQ_E_HDR_UNDEF, `RCEQ_E_NUM_CHAR,
        `RCEQ_E_SUF_BAD, `RCEQ_E_SUF_UNWANT, `RCEQ_E_CHAR_PARM};
    // cmd: cls, rst, ext, fetch, done, math on, math off, number
    rceq_top dut (.ref_clk_i, .rst_b_i, .fault_vld_i, .fault_cls_i,
        .num_vld_i(cmd[7]), .num_exp_i, .num_digits_i, .cls_i(cmd[0]),
        .rst_cmd_i(cmd[1]), .err_rd_i, .err_rd_vld_o, .err_code_o,
        .err_lamp_o, .beep_o, .err_count_o, .init_cmd_i, .read_cmd_i,
        .meas_cmd_i, .bus_trg_i, .ext_trg_i(cmd[2]), .trg_src_i,
        .meas_done_i(cmd[4]), .fetch_cmd_i(cmd[3]), .mem_empty_i,
        .wait_trg_o, .meas_start_o, .math_en_i(cmd[5]), .math_sel_i,
        .math_off_i(cmd[6]), .meas_fn_i, .math_onehot_o);
    rceq_host host (.ref_clk_i, .err_rd_o(err_rd_i), .init_o(init_cmd_i),
        .read_o(read_cmd_i), .meas_o(meas_cmd_i), .bus_trg_o(bus_trg_i));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task complete_run();
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    function void log_err(input logic [15:0] c);
        if (mq.size() == 20 && !ovf) begin
            mq[19] = `RCEQ_E_TOO_MANY;
            ovf = 1'b1;
        end else if (!ovf) begin
            mq.push_back(c);
        end
    endfunction
    task poke(input int k);
        @(negedge ref_clk_i) cmd[k] = 1'b1;
        @(negedge ref_clk_i) cmd[k] = 1'b0;
    endtask
    task fault(input logic [4:0] c);
        bit b;
        b = mq.size() < 20;
        @(negedge ref_clk_i) fault_vld_i = 1'b1;
        fault_cls_i = c;
        @(negedge ref_clk_i) fault_vld_i = 1'b0;
        if (b) chk("beep", beep_o, 1);
        log_err(ecode[c]);
        repeat ($urandom % 3) @(negedge ref_clk_i);
    endtask
    task num(input logic [15:0] x, input logic [8:0] d, input logic [15:0] c);
        num_exp_i = x;
        num_digits_i = d;
        poke(7);
        if (c) log_err(c);
    endtask
    task rd1();
        exp_q.push_back(mq.size() ? mq.pop_front() : 16'h0000);
        ovf = 1'b0;
        host.rd();
    endtask
    task settle();
        repeat (4) @(negedge ref_clk_i);
        chk("count", err_count_o, mq.size());
        chk("lamp", err_lamp_o, mq.size() != 0);
    endtask
    task drain();
        while (mq.size()) rd1();
        rd1();
        settle();
    endtask
    task wait_start(input bit e);
        bit got;
        got = 0;
        repeat (8) @(negedge ref_clk_i) got |= (meas_start_o === 1'b1);
        chk("start", got, e);
    endtask
    always @(negedge ref_clk_i) begin
        if (err_rd_vld_o === 1'b1) begin
            chk("code", err_code_o,
                exp_q.size() ? exp_q.pop_front() : 16'h0001);
        end
    end
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #100000;
        bad_count++;
        complete_run();
    end
    initial begin
        cmd = 8'h00;
        {fault_vld_i, fault_cls_i, num_exp_i, num_digits_i, trg_src_i} = 0;
        {math_sel_i, meas_fn_i, rst_b_i, ovf} = 0;
        mem_empty_i = 1'b1;
        seed = $urandom(32'h668E);
        repeat (16) @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        settle();
        rd1();
        for (i = 1; i < 14; i++) fault(i);
        num(16'h7D00, 9'h0FF, 16'h0000);
        num(16'h7D01, 9'h001, `RCEQ_E_NUM_OVF);
        num(16'h0000, 9'h100, `RCEQ_E_TOO_DIGITS);
        poke(1);
        settle();
        drain();
        for (i = 0; i < 22; i++) fault(1 + $urandom % 13);
        settle();
        rd1();
        fault(1 + $urandom % 13);
        settle();
        drain();
        fault(5'h02);
        poke(0);
        mq.delete();
        settle();
        trg_src_i = `RCEQ_SRC_BUS;
        host.fire();
        log_err(`RCEQ_E_TRG_IGN);
        wait_start(0);
        trg_src_i = `RCEQ_SRC_EXT;
        poke(2);
        wait_start(0);
        for (i = 0; i < 3; i++) begin
            trg_src_i = i[1:0];
            host.arm((i + 2) % 3);
            if (i) begin
                @(negedge ref_clk_i);
                chk("wait", wait_trg_o, 1);
            end
            if (i == 1) host.fire();
            if (i == 2) poke(2);
            wait_start(1);
            if (i == 1) begin
                host.arm(0);
                log_err(`RCEQ_E_INIT_IGN);
            end
            poke(4);
        end
        trg_src_i = `RCEQ_SRC_BUS;
        host.arm(1);
        log_err(`RCEQ_E_TRG_DEAD);
        @(negedge ref_clk_i);
        chk("wait", wait_trg_o, 1);
        host.fire();
        wait_start(1);
        poke(4);
        poke(3);
        log_err(`RCEQ_E_DATA_STALE);
        mem_empty_i = 1'b0;
        poke(3);
        drain();
        for (i = 0; i < 8; i++) begin
            math_sel_i = i[2:0];
            poke(5);
            @(negedge ref_clk_i);
            chk("math", math_onehot_o, 8'h01 << i);
        end
        meas_fn_i = `RCEQ_FN_CONT;
        repeat (3) @(negedge ref_clk_i);
        chk("math", math_onehot_o, 0);
        meas_fn_i = `RCEQ_FN_DIODE;
        poke(5);
        @(negedge ref_clk_i);
        chk("math", math_onehot_o, 0);
        meas_fn_i = 4'h0;
        poke(5);
        poke(6);
        @(negedge ref_clk_i);
        chk("math", math_onehot_o, 0);
        chk("pending", exp_q.size(), 0);
        complete_run();
    end
endmodule

bind rceq_top rceq_asserts chk_u (
    .ref_clk_i, .rst_b_i, .fault_vld_i, .fault_cls_i, .cls_i, .err_rd_i,
    .meas_fn_i, .err_rd_vld_o, .err_code_o, .err_lamp_o, .beep_o,
    .err_count_o, .wait_trg_o, .meas_start_o, .math_onehot_o);
